// ---- src/fscpu_regs.svh ----
// Purpose: Constants for the five-stage pipeline core.
// Assumes: One core clock.
// Notes: Field positions of the simplified instruction word used by the core.
`ifndef FSCPU_REGS_SVH
`define FSCPU_REGS_SVH
`define FSCPU_PC_STEP_W 32'h0000_0004
`define FSCPU_PC_STEP_C 32'h0000_0002
`define FSCPU_PC_RESET 32'h0000_0000
`define FSCPU_OP_HI 31
`define FSCPU_OP_LO 28
`define FSCPU_SETF_BIT 27
`define FSCPU_USER_BIT 26
`define FSCPU_PRE_BIT 25
`define FSCPU_IMM_BIT 24
`define FSCPU_SIZE_HI 23
`define FSCPU_SIZE_LO 22
`define FSCPU_XTOP_BIT 21
`define FSCPU_YTOP_BIT 20
`define FSCPU_RD_HI 19
`define FSCPU_RD_LO 16
`define FSCPU_RN_HI 15
`define FSCPU_RN_LO 12
`define FSCPU_RM_HI 11
`define FSCPU_RM_LO 8
`define FSCPU_ROT_HI 11
`define FSCPU_ROT_LO 8
`define FSCPU_IMM8_HI 7
`define FSCPU_IMM8_LO 0
`endif

// ---- src/fscpu_pkg.sv ----
// Purpose: Types shared by the pipeline core files.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Opcode values are the top nibble of the internal instruction word.
`default_nettype none
package fscpu_pkg;
   typedef enum logic [3:0] {
      FSCPU_OP_NOP = 4'h0, FSCPU_OP_ADD = 4'h1, FSCPU_OP_SUB = 4'h2, FSCPU_OP_AND = 4'h3,
      FSCPU_OP_ORR = 4'h4, FSCPU_OP_MOV = 4'h5, FSCPU_OP_SMUL = 4'h6, FSCPU_OP_LDR = 4'h7,
      FSCPU_OP_STR = 4'h8, FSCPU_OP_LDC = 4'h9, FSCPU_OP_STC = 4'hA, FSCPU_OP_SWP = 4'hB,
      FSCPU_OP_RSV = 4'hF
   } fscpu_op_t;
   typedef enum logic [1:0] {
      FSCPU_SZ_BYTE = 2'h0, FSCPU_SZ_HALF = 2'h1, FSCPU_SZ_WORD = 2'h2
   } fscpu_size_t;
endpackage : fscpu_pkg
`default_nettype wire

// ---- src/fscpu_expand.sv ----
// Purpose: Expands a 16-bit compact instruction to its full-width equivalent.
// Assumes: Compact layout op[15:12] rd[10:8] rn[6:4] rm[2:0]; bits 11, 7 and 3 are ignored.
// Notes: The result drives the same decode and register set as full-width code.
`include "fscpu_regs.svh"
`default_nettype none
module fscpu_expand (
   // Compact instruction in.
   input wire logic [15:0] i_half,
   // Full-width instruction out.
   output logic [31:0] o_word
);
   // Fields are placed so the full-width decoder sees the same operation.
   always_comb begin
      o_word = 32'h0000_0000;
      o_word[`FSCPU_OP_HI:`FSCPU_OP_LO] = i_half[15:12];
      o_word[`FSCPU_SETF_BIT] = 1'b1; // Compact arithmetic always updates flags.
      o_word[`FSCPU_SIZE_HI:`FSCPU_SIZE_LO] = 2'h2;
      o_word[`FSCPU_RD_HI:`FSCPU_RD_LO] = {1'b0, i_half[10:8]};
      o_word[`FSCPU_RN_HI:`FSCPU_RN_LO] = {1'b0, i_half[6:4]};
      o_word[`FSCPU_RM_HI:`FSCPU_RM_LO] = {1'b0, i_half[2:0]};
   end
endmodule : fscpu_expand
`default_nettype wire

// ---- src/fscpu_core.sv ----
// Purpose: Five-stage pipeline core with separate instruction and data ports.
// Assumes: Memories answer in the same cycle; software keeps accesses aligned.
// Notes: Simplified internal instruction encoding, see fscpu_regs.svh.
// Summary of operation
// - Instructions pass fetch, decode, execute, memory and writeback in order.
// - Each stage holds a different instruction at once.
// - The program counter addresses the instruction being fetched.
// - Separate instruction and data buses may both be busy in one cycle.
// - Only load, store, coprocessor transfers and swap use the data port.
// - Data transfers are byte, halfword or word.
// - Pending register results are forwarded or the pipeline stalls.
// - Full-width and compact instruction states both execute.
// - Compact instructions act like full-width ones on the same registers.
// - Post-indexed user-privilege accesses drive the privilege indicator low; pre-indexed ones leave it high.
// - Immediates are an 8-bit value rotated right by an even count.
// - Halfword multiply picks top or bottom 16 bits of each source.
// - Flags change only when the flag-setting bit is present.
`include "fscpu_regs.svh"
`default_nettype none
module fscpu_core #(
   parameter int NREG = 16
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // State select: high for compact instructions.
   input wire logic i_compact,
   // Instruction port.
   output logic [31:0] o_iaddr,
   output logic o_ireq,
   input wire logic [31:0] i_idata,
   // Data port.
   output logic [31:0] o_daddr,
   output logic [31:0] o_dwdata,
   output logic o_dreq,
   output logic o_dwrite,
   output logic [1:0] o_dsize,
   output logic o_data_user_privilege_n,
   input wire logic [31:0] i_drdata,
   // Condition flags N Z C V.
   output logic [3:0] o_flags
);
   // The register index fields are four bits wide, so no other bank size can be served.
   if (NREG != 16) begin : g_nreg_check
      $error("NREG must be 16");
   end

   // Rotate an 8-bit value right by twice the rotate field.
   function automatic logic [31:0] rot_imm(input logic [31:0] ins);
      logic [31:0] v;
      logic [4:0] sh;
      v = {24'h00_0000, ins[`FSCPU_IMM8_HI:`FSCPU_IMM8_LO]};
      sh = {ins[`FSCPU_ROT_HI:`FSCPU_ROT_LO], 1'b0};
      return (v >> sh) | (v << (6'd32 - {1'b0, sh}));
   endfunction : rot_imm

   // True for instructions allowed on the data port.
   function automatic logic is_mem(input logic [3:0] op);
      return op inside {fscpu_pkg::FSCPU_OP_LDR, fscpu_pkg::FSCPU_OP_STR,
         fscpu_pkg::FSCPU_OP_LDC, fscpu_pkg::FSCPU_OP_STC, fscpu_pkg::FSCPU_OP_SWP};
   endfunction : is_mem

   // True for instructions that write a register result.
   function automatic logic writes_rd(input logic [3:0] op);
      return !(op inside {fscpu_pkg::FSCPU_OP_NOP, fscpu_pkg::FSCPU_OP_STR,
         fscpu_pkg::FSCPU_OP_STC, fscpu_pkg::FSCPU_OP_RSV});
   endfunction : writes_rd

   // True when a valid stage instruction will write register idx.
   function automatic logic hits(input logic v, input logic [31:0] ins, input logic [3:0] idx);
      return v && writes_rd(ins[`FSCPU_OP_HI:`FSCPU_OP_LO]) &&
         ins[`FSCPU_RD_HI:`FSCPU_RD_LO] == idx;
   endfunction : hits

   logic [31:0] pc_q, pc_d;
   logic [31:0] fd_ins_q, fd_ins_d;
   logic fd_v_q, fd_v_d;
   logic [31:0] de_ins_q, de_ins_d, de_a_q, de_a_d, de_b_q, de_b_d;
   logic de_v_q, de_v_d;
   logic [31:0] em_ins_q, em_ins_d, em_res_q, em_res_d, em_st_q, em_st_d;
   logic em_v_q, em_v_d;
   logic [31:0] mw_ins_q, mw_ins_d, mw_res_q, mw_res_d;
   logic mw_v_q, mw_v_d;
   logic [3:0] flags_q, flags_d;
   logic [31:0] rf_q [NREG];
   logic [31:0] rf_d [NREG];
   logic [31:0] exp_word, fetched, ra, rb, res, em_fwd;
   logic [3:0] de_op, em_op, mw_op, dec_op, dec_rn, dec_rm, de_rd;
   logic stall, mw_we;
   logic [15:0] mx, my;

   fscpu_expand u_expand (
      .i_half(pc_q[1] ? i_idata[31:16] : i_idata[15:0]),
      .o_word(exp_word)
   );

   assign fetched = i_compact ? exp_word : i_idata;
   assign de_op = de_ins_q[`FSCPU_OP_HI:`FSCPU_OP_LO];
   assign em_op = em_ins_q[`FSCPU_OP_HI:`FSCPU_OP_LO];
   assign mw_op = mw_ins_q[`FSCPU_OP_HI:`FSCPU_OP_LO];
   assign dec_op = fd_ins_q[`FSCPU_OP_HI:`FSCPU_OP_LO];
   assign dec_rn = fd_ins_q[`FSCPU_RN_HI:`FSCPU_RN_LO];
   assign dec_rm = fd_ins_q[`FSCPU_RM_HI:`FSCPU_RM_LO];
   assign mw_we = mw_v_q && writes_rd(mw_op);
   assign de_rd = de_ins_q[`FSCPU_RD_HI:`FSCPU_RD_LO];
   // A load in the memory stage forwards the bus data, which answers in the same cycle.
   assign em_fwd = is_mem(em_op) ? i_drdata : em_res_q;

   // Load-use hazard: a load result is not ready in execute, so decode waits a cycle.
   assign stall = fd_v_q && de_v_q && is_mem(de_op) && writes_rd(de_op) &&
      dec_op != fscpu_pkg::FSCPU_OP_NOP &&
      (de_ins_q[`FSCPU_RD_HI:`FSCPU_RD_LO] == dec_rn ||
       de_ins_q[`FSCPU_RD_HI:`FSCPU_RD_LO] == dec_rm);

   // Operand read with forwarding; the youngest producer wins, so execute is tested last.
   always_comb begin
      ra = rf_q[dec_rn];
      rb = rf_q[dec_rm];
      if (hits(mw_v_q, mw_ins_q, dec_rn)) ra = mw_res_q;
      if (hits(mw_v_q, mw_ins_q, dec_rm)) rb = mw_res_q;
      if (hits(em_v_q, em_ins_q, dec_rn)) ra = em_fwd;
      if (hits(em_v_q, em_ins_q, dec_rm)) rb = em_fwd;
      // A load in execute never gets here with a match, because decode stalls for it.
      if (hits(de_v_q, de_ins_q, dec_rn) && !is_mem(de_op)) ra = res;
      if (hits(de_v_q, de_ins_q, dec_rm) && !is_mem(de_op)) rb = res;
      if (fd_ins_q[`FSCPU_IMM_BIT]) rb = rot_imm(fd_ins_q);
   end

   // Execute: ALU, halfword multiply and flag update.
   always_comb begin
      mx = de_ins_q[`FSCPU_XTOP_BIT] ? de_a_q[31:16] : de_a_q[15:0];
      my = de_ins_q[`FSCPU_YTOP_BIT] ? de_b_q[31:16] : de_b_q[15:0];
      flags_d = flags_q;
      unique case (de_op)
         fscpu_pkg::FSCPU_OP_ADD: res = de_a_q + de_b_q;
         fscpu_pkg::FSCPU_OP_SUB: res = de_a_q - de_b_q;
         fscpu_pkg::FSCPU_OP_AND: res = de_a_q & de_b_q;
         fscpu_pkg::FSCPU_OP_ORR: res = de_a_q | de_b_q;
         fscpu_pkg::FSCPU_OP_MOV: res = de_b_q;
         fscpu_pkg::FSCPU_OP_SMUL: res = $signed(mx) * $signed(my);
         default: res = de_a_q + de_b_q; // Memory ops compute the address.
      endcase
      if (de_v_q && de_ins_q[`FSCPU_SETF_BIT] && !is_mem(de_op)) begin
         flags_d = {res[31], res == 32'h0000_0000, flags_q[1:0]};
      end
   end

   // Pipeline advance with stall; older stages always move on.
   always_comb begin
      pc_d = pc_q + (i_compact ? `FSCPU_PC_STEP_C : `FSCPU_PC_STEP_W);
      fd_ins_d = fetched;
      fd_v_d = 1'b1;
      de_ins_d = fd_ins_q;
      de_a_d = ra;
      de_b_d = rb;
      de_v_d = fd_v_q;
      if (stall) begin
         pc_d = pc_q;
         fd_ins_d = fd_ins_q;
         fd_v_d = fd_v_q;
         de_v_d = 1'b0; // A bubble enters execute.
      end
      em_ins_d = de_ins_q;
      em_res_d = res;
      em_st_d = rf_q[de_rd];
      // Store data is forwarded as well, so a store right behind its producer is safe.
      if (hits(mw_v_q, mw_ins_q, de_rd)) em_st_d = mw_res_q;
      if (hits(em_v_q, em_ins_q, de_rd)) em_st_d = em_fwd;
      em_v_d = de_v_q;
      mw_ins_d = em_ins_q;
      mw_res_d = (em_op == fscpu_pkg::FSCPU_OP_LDR || em_op == fscpu_pkg::FSCPU_OP_LDC ||
         em_op == fscpu_pkg::FSCPU_OP_SWP) ? i_drdata : em_res_q;
      mw_v_d = em_v_q;
      rf_d = rf_q;
      if (mw_we) rf_d[mw_ins_q[`FSCPU_RD_HI:`FSCPU_RD_LO]] = mw_res_q;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pc_q <= `FSCPU_PC_RESET;
         fd_v_q <= 1'b0;
         de_v_q <= 1'b0;
         em_v_q <= 1'b0;
         mw_v_q <= 1'b0;
         flags_q <= 4'h0;
         fd_ins_q <= 32'h0000_0000;
         de_ins_q <= 32'h0000_0000;
         em_ins_q <= 32'h0000_0000;
         mw_ins_q <= 32'h0000_0000;
         de_a_q <= 32'h0000_0000;
         de_b_q <= 32'h0000_0000;
         em_res_q <= 32'h0000_0000;
         em_st_q <= 32'h0000_0000;
         mw_res_q <= 32'h0000_0000;
         for (int i = 0; i < NREG; i++) rf_q[i] <= 32'h0000_0000;
      end else begin
         pc_q <= pc_d;
         fd_v_q <= fd_v_d;
         de_v_q <= de_v_d;
         em_v_q <= em_v_d;
         mw_v_q <= mw_v_d;
         flags_q <= flags_d;
         fd_ins_q <= fd_ins_d;
         de_ins_q <= de_ins_d;
         em_ins_q <= em_ins_d;
         mw_ins_q <= mw_ins_d;
         de_a_q <= de_a_d;
         de_b_q <= de_b_d;
         em_res_q <= em_res_d;
         em_st_q <= em_st_d;
         mw_res_q <= mw_res_d;
         rf_q <= rf_d;
      end
   end

   // Ports; both buses run in the same cycle when needed.
   assign o_iaddr = pc_q;
   assign o_ireq = !i_sys_rst;
   assign o_dreq = em_v_q && is_mem(em_op);
   assign o_daddr = em_res_q;
   assign o_dwdata = em_st_q;
   assign o_dwrite = o_dreq && (em_op == fscpu_pkg::FSCPU_OP_STR ||
      em_op == fscpu_pkg::FSCPU_OP_STC);
   assign o_dsize = em_ins_q[`FSCPU_SIZE_HI:`FSCPU_SIZE_LO];
   // Pre-indexed user accesses are illegal; the indicator stays high for them.
   assign o_data_user_privilege_n = !(o_dreq && em_ins_q[`FSCPU_USER_BIT] &&
      !em_ins_q[`FSCPU_PRE_BIT]);
   assign o_flags = flags_q;

   flags_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !(de_v_q && de_ins_q[`FSCPU_SETF_BIT]) |=> $stable(flags_q))
      else $error("flags changed without flag-setting bit");
   dport_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !(de_v_q && is_mem(de_op)) |=> !o_dreq) else $error("data port used by non-memory op");
   stall_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stall |=> $stable(pc_q) && !de_v_q) else $error("stall did not hold fetch");
   pc_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !stall && !i_compact |=> pc_q == $past(pc_q) + 32'h0000_0004)
      else $error("pc did not step");
   pipe_flow_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      de_v_q |=> em_v_q ##1 mw_v_q) else $error("instruction lost in pipe");
   priv_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !o_data_user_privilege_n |-> o_dreq && em_ins_q[`FSCPU_USER_BIT])
      else $error("privilege low without user access");
   dsize_ok_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_dreq |-> o_dsize != 2'h3) else $error("illegal access size");
   wb_forward_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      em_v_q && writes_rd(em_op) |=> mw_v_q && mw_ins_q == $past(em_ins_q))
      else $error("result not carried to writeback");
endmodule : fscpu_core
`default_nettype wire

// ---- sim/fscpu_mem_model.sv ----
// Purpose: Instruction and data memory model facing the pipeline core.
// Assumes: Both memories answer in the same cycle, as the core expects.
// Notes: Idle read buses show a moving pattern, never the last value.
`default_nettype none
module fscpu_mem_model (
   // Clock.
   input wire logic i_clk,
   // Instruction side.
   input wire logic [31:0] i_iaddr,
   input wire logic i_ireq,
   output logic [31:0] o_idata,
   // Data side.
   input wire logic [31:0] i_daddr,
   input wire logic [31:0] i_dwdata,
   input wire logic i_dreq,
   input wire logic i_dwrite,
   output logic [31:0] o_drdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rom [0:63];
   logic [31:0] ram [0:63];
   logic [31:0] noise_q = 32'h5A5A_A5A5;
   // Word index only, so a misaligned access would silently alias.
   assign o_idata = i_ireq ? rom[i_iaddr[7:2]] : noise_q;
   assign o_drdata = (i_dreq && !i_dwrite) ? ram[i_daddr[7:2]] : ~noise_q;
   // Stores land at the edge; the pattern moves each cycle so stale reads show.
   always @(posedge i_clk) begin
      noise_q <= {noise_q[30:0], noise_q[31]} ^ 32'h0000_0001;
      if (i_dreq && i_dwrite) begin
         ram[i_daddr[7:2]] <= i_dwdata;
      end
   end
endmodule : fscpu_mem_model
`default_nettype wire

// ---- sim/test_five_stage_cpu_pipeline_core.sv ----
// Purpose: Self-checking bench for the five-stage pipeline core.
// Assumes: Memory model answers in the same cycle.
// Notes: Data accesses and fetch addresses are logged and judged per test.
`default_nettype none
module test_five_stage_cpu_pipeline_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_compact = 1'b0;
   logic [31:0] iaddr, idata, daddr, dwdata, drdata;
   logic ireq, dreq, dwrite, priv_n;
   logic [1:0] dsize;
   logic [3:0] flags;
   int err_count = 0;
   int checks_done = 0;
   logic [31:0] fetch_q [$];
   logic [68:0] dacc_q [$];
   fscpu_core fscpu_core_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_compact(i_compact),
      .o_iaddr(iaddr), .o_ireq(ireq), .i_idata(idata), .o_daddr(daddr), .o_dwdata(dwdata),
      .o_dreq(dreq), .o_dwrite(dwrite), .o_dsize(dsize), .o_data_user_privilege_n(priv_n),
      .i_drdata(drdata), .o_flags(flags));
   fscpu_mem_model fscpu_mem_model_i (.i_clk(i_clk), .i_iaddr(iaddr), .i_ireq(ireq),
      .o_idata(idata), .i_daddr(daddr), .i_dwdata(dwdata), .i_dreq(dreq),
      .i_dwrite(dwrite), .o_drdata(drdata));
   // Free-running 50 MHz clock.
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   // Log every fetch and every data access outside reset.
   always @(posedge i_clk) begin
      if (!i_sys_rst && ireq) fetch_q.push_back(iaddr);
      if (!i_sys_rst && dreq) dacc_q.push_back({ireq, dwrite, priv_n, dsize, daddr, dwdata});
   end
   // Compares any value, widened to the access record width.
   task automatic chk(input logic [68:0] got, input logic [68:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Instruction word: op, flag byte {S,user,pre,imm,size,xtop,ytop}, rd, rn, rm/rot, imm8.
   function automatic logic [31:0] enc(input logic [3:0] op, input logic [7:0] fl,
      input logic [3:0] rd, input logic [3:0] rn, input logic [3:0] rm, input logic [7:0] i8);
      return {op, fl, rd, rn, rm, i8};
   endfunction : enc
   // Reset for 16 cycles, checking the idle levels, then release.
   task automatic do_reset(input logic cmp);
      i_sys_rst <= 1'b1;
      i_compact <= cmp;
      repeat (16) @(posedge i_clk);
      chk({ireq, priv_n}, 2'b01);
      fetch_q.delete();
      dacc_q.delete();
      i_sys_rst <= 1'b0;
   endtask : do_reset
   // Program with forwarding, a load-use stall, rotated immediates and halfword multiply.
   task automatic test_pipeline();
      logic [31:0] p [0:15];
      for (int k = 0; k < 64; k++) fscpu_mem_model_i.rom[k] = 32'h0000_0000;
      p = '{default: 32'h0000_0000};
      p[0] = enc(fscpu_pkg::FSCPU_OP_MOV, 8'h10, 4'h1, 4'h0, 4'h4, 8'h12);
      p[1] = enc(fscpu_pkg::FSCPU_OP_MOV, 8'h10, 4'h2, 4'h0, 4'h0, 8'h40);
      p[2] = enc(fscpu_pkg::FSCPU_OP_ADD, 8'h00, 4'h3, 4'h1, 4'h2, 8'h00);
      p[5] = enc(fscpu_pkg::FSCPU_OP_STR, 8'h58, 4'h3, 4'h2, 4'h0, 8'h00);
      p[6] = enc(fscpu_pkg::FSCPU_OP_LDR, 8'h38, 4'h4, 4'h2, 4'h0, 8'h00);
      p[7] = enc(fscpu_pkg::FSCPU_OP_ADD, 8'h80, 4'h5, 4'h4, 4'h4, 8'h00);
      p[8] = enc(fscpu_pkg::FSCPU_OP_MOV, 8'h10, 4'h9, 4'h0, 4'h8, 8'h03);
      p[9] = enc(fscpu_pkg::FSCPU_OP_ORR, 8'h10, 4'h9, 4'h9, 4'h0, 8'h05);
      p[10] = enc(fscpu_pkg::FSCPU_OP_SMUL, 8'h02, 4'h8, 4'h9, 4'h9, 8'h00);
      p[11] = enc(fscpu_pkg::FSCPU_OP_SUB, 8'h80, 4'h6, 4'h1, 4'h1, 8'h00);
      p[12] = enc(fscpu_pkg::FSCPU_OP_SUB, 8'h00, 4'h7, 4'h2, 4'h1, 8'h00);
      p[14] = enc(fscpu_pkg::FSCPU_OP_STR, 8'h10, 4'h5, 4'h2, 4'h0, 8'h00);
      p[15] = enc(fscpu_pkg::FSCPU_OP_STR, 8'h14, 4'h8, 4'h2, 4'h0, 8'h00);
      for (int k = 0; k < 16; k++) fscpu_mem_model_i.rom[k] = p[k];
      do_reset(1'b0);
      repeat (40) @(posedge i_clk);
      chk(fetch_q.size() >= 3, 1'b1);
      chk(fetch_q[0], 32'h0000_0000);
      chk(fetch_q[1], 32'h0000_0004);
      chk(fetch_q[2], 32'h0000_0008);
      chk(dacc_q.size(), 4);
      chk(dacc_q[0], {5'b11010, 32'h0000_0040, 32'h1200_0040});
      chk(dacc_q[1][68:32], {5'b10110, 32'h0000_0040});
      chk(dacc_q[2][68:32], {5'b11100, 32'h0000_0040});
      chk(dacc_q[2][7:0], 8'h80);
      chk(dacc_q[3][68:32], {5'b11101, 32'h0000_0040});
      chk(dacc_q[3][15:0], 16'h000F);
      chk(flags, 4'b0100);
      $display("test_pipeline done");
   endtask : test_pipeline
   // Compact state steps the fetch address by halfwords; its code on a cleared bank sets Z.
   task automatic test_compact();
      do_reset(1'b1);
      repeat (8) @(posedge i_clk);
      chk(fetch_q.size() >= 3, 1'b1);
      chk(fetch_q[0], 32'h0000_0000);
      chk(fetch_q[1], 32'h0000_0002);
      chk(fetch_q[2], 32'h0000_0004);
      chk(flags, 4'b0100);
      $display("test_compact done");
   endtask : test_compact
   // Ends the run with the counts and the verdict.
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   // Both tests take under 100 cycles; the limit leaves a wide margin.
   initial begin
      #8000;
      err_count++;
      final_report();
   end
   // Main sequence.
   initial begin
      test_pipeline();
      test_compact();
      final_report();
   end
endmodule : test_five_stage_cpu_pipeline_core
`default_nettype wire
